// ---- logic/urx_receiver.sv ----
// serial receiver with oversampled start detection, two-deep buffer and wishbone registers
//
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module urx_receiver (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [urx_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic rx_i,
	input wire logic global_irq_en,
	output logic rx_irq,
	output logic rx_pin_owned
);
	logic ack_r;
	logic [31:0] dat_r;
	logic irq_en_r;
	logic rx_en_r;
	logic dbl_speed_r;
	logic par_en_r;
	logic par_odd_r;
	logic stop_sel_r;
	logic [2:0] csz_r;
	logic [15:0] baud_div_r, baud_cnt_r;
	logic tick;
	urx_pkg::urx_state_e state_r;
	logic [4:0] samp_r;
	logic [4:0] cur;
	logic [4:0] spb;
	logic [4:0] vfirst;
	logic [3:0] bit_idx_r, nbits;
	logic [2:0] vote_r;
	logic [8:0] shift_r;
	logic par_bit_r;
	logic bit_val;
	logic decide;
	logic frame_done;
	logic valid_start;
	logic overrun;
	logic pend_valid_r, ovr_r;
	urx_pkg::urx_entry_s pend_r;
	urx_pkg::urx_entry_s mem_r [0:1];
	urx_pkg::urx_entry_s head;
	logic rd_ptr_r;
	logic [1:0] count_r;
	logic rx_done;
	logic push;
	logic pop;
	logic req;
	logic wr_ack;
	logic rd_ack;
	logic frame_err_vis, par_err_vis;

	// majority of three samples
	function automatic logic maj3(input logic [2:0] s);
		maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction

	// data bits per character from the size field
	function automatic logic [3:0] char_bits(input logic [2:0] csz);
		char_bits = (csz == urx_pkg::CSZ_NINE) ? urx_pkg::CHAR_NINE : urx_pkg::CHAR_BASE + {2'h0, csz[1:0]};
	endfunction

	// bus request qualifiers
	assign req = wb_cyc_i & wb_stb_i;
	assign wr_ack = req & wb_we_i & ack_r;
	assign rd_ack = req & ~wb_we_i & ack_r;

	// buffer status
	assign rx_done = (count_r != 2'h0);
	assign head = mem_r[rd_ptr_r];
	assign frame_err_vis = rx_done & head.frame_err;
	assign par_err_vis = rx_done & head.par_err & par_en_r;
	assign pop = rd_ack & (wb_adr_i == urx_pkg::ADR_DATA) & rx_done;
	assign push = pend_valid_r & (count_r != urx_pkg::FIFO_DEPTH) & rx_en_r;

	// interrupt only from the receive-complete flag, never from errors
	assign rx_irq = irq_en_r & rx_done & global_irq_en;
	assign rx_pin_owned = rx_en_r;
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	// one wait state: ack rises the cycle after the request and drops after one cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req & ~ack_r;
		end
	end

	// read data captured together with the rising ack
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dat_r <= 32'h0000_0000;
		end else if (req & ~ack_r) begin
			dat_r <= 32'h0000_0000;
			case (wb_adr_i)
				urx_pkg::ADR_STATUS: begin
					dat_r[urx_pkg::ST_RX_DONE] <= rx_done;
					dat_r[urx_pkg::ST_FRAME_ERR] <= frame_err_vis;
					dat_r[urx_pkg::ST_OVERRUN] <= ovr_r;
					dat_r[urx_pkg::ST_PAR_ERR] <= par_err_vis;
					dat_r[urx_pkg::ST_DOUBLE] <= dbl_speed_r;
				end
				urx_pkg::ADR_CONTROL: begin
					dat_r[urx_pkg::CT_IRQ_EN] <= irq_en_r;
					dat_r[urx_pkg::CT_RX_ENABLE] <= rx_en_r;
					dat_r[urx_pkg::CT_NINTH] <= rx_done & head.data[8];
				end
				urx_pkg::ADR_FORMAT: begin
					dat_r[urx_pkg::FM_PAR_EN] <= par_en_r;
					dat_r[urx_pkg::FM_PAR_ODD] <= par_odd_r;
					dat_r[urx_pkg::FM_STOP] <= stop_sel_r;
					dat_r[urx_pkg::FM_CSZ_LSB +: 3] <= csz_r;
				end
				urx_pkg::ADR_DATA: dat_r[7:0] <= rx_done ? head.data[7:0] : 8'h00;
				urx_pkg::ADR_BAUD: dat_r[15:0] <= baud_div_r;
				default: dat_r <= 32'h0000_0000;
			endcase
		end
	end

	// software-written configuration; error flags in status are not writable
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_en_r <= 1'b0;
			rx_en_r <= 1'b0;
			dbl_speed_r <= 1'b0;
			par_en_r <= 1'b0;
			par_odd_r <= 1'b0;
			stop_sel_r <= 1'b0;
			csz_r <= urx_pkg::CSZ_RST;
			baud_div_r <= urx_pkg::BAUD_RST;
		end else if (wr_ack) begin
			case (wb_adr_i)
				urx_pkg::ADR_STATUS: if (wb_sel_i[0]) dbl_speed_r <= wb_dat_i[urx_pkg::ST_DOUBLE];
				urx_pkg::ADR_CONTROL: if (wb_sel_i[0]) begin
					irq_en_r <= wb_dat_i[urx_pkg::CT_IRQ_EN];
					rx_en_r <= wb_dat_i[urx_pkg::CT_RX_ENABLE];
				end
				urx_pkg::ADR_FORMAT: if (wb_sel_i[0]) begin
					par_en_r <= wb_dat_i[urx_pkg::FM_PAR_EN];
					par_odd_r <= wb_dat_i[urx_pkg::FM_PAR_ODD];
					stop_sel_r <= wb_dat_i[urx_pkg::FM_STOP];
					csz_r <= wb_dat_i[urx_pkg::FM_CSZ_LSB +: 3];
				end
				urx_pkg::ADR_BAUD: begin
					if (wb_sel_i[0]) baud_div_r[7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1]) baud_div_r[15:8] <= wb_dat_i[15:8];
				end
				default: ;
			endcase
		end
	end

	// oversampling tick divider, held while the receiver is off
	assign tick = rx_en_r & (baud_cnt_r == baud_div_r);
	always_ff @(posedge clk) begin
		if (!rst_n || !rx_en_r || tick) begin
			baud_cnt_r <= 16'h0000;
		end else begin
			baud_cnt_r <= baud_cnt_r + 16'h0001;
		end
	end

	// sample timing and bit decisions
	assign spb = dbl_speed_r ? urx_pkg::SPB_DOUBLE : urx_pkg::SPB_NORMAL;
	assign vfirst = dbl_speed_r ? urx_pkg::VOTE_DOUBLE : urx_pkg::VOTE_NORMAL;
	assign cur = samp_r + urx_pkg::SAMPLE_ONE;
	assign nbits = char_bits(csz_r);
	assign bit_val = maj3({vote_r[1:0], rx_i});
	assign decide = tick & (state_r != urx_pkg::S_IDLE) & (cur == vfirst + urx_pkg::VOTE_SPAN);
	assign valid_start = decide & (state_r == urx_pkg::S_START) & ~bit_val;
	assign frame_done = decide & (state_r == urx_pkg::S_STOP);
	assign overrun = valid_start & pend_valid_r & (count_r == urx_pkg::FIFO_DEPTH);

	// receive state machine; disable abandons any frame at once
	always_ff @(posedge clk) begin
		if (!rst_n || !rx_en_r) begin
			state_r <= urx_pkg::S_IDLE;
			samp_r <= 5'h00;
			bit_idx_r <= 4'h0;
		end else if (tick) begin
			case (state_r)
				urx_pkg::S_IDLE: begin
					if (vote_r[0] & ~rx_i) begin
						state_r <= urx_pkg::S_START;
						samp_r <= urx_pkg::SAMPLE_ONE;
					end
				end
				urx_pkg::S_START: begin
					if (decide & bit_val) begin
						state_r <= urx_pkg::S_IDLE;
					end else if (cur == spb) begin
						state_r <= urx_pkg::S_DATA;
						samp_r <= 5'h00;
						bit_idx_r <= 4'h0;
					end else begin
						samp_r <= cur;
					end
				end
				urx_pkg::S_DATA: begin
					if (cur == spb) begin
						samp_r <= 5'h00;
						bit_idx_r <= bit_idx_r + 4'h1;
						if (bit_idx_r == nbits - 4'h1) begin
							state_r <= par_en_r ? urx_pkg::S_PARITY : urx_pkg::S_STOP;
						end
					end else begin
						samp_r <= cur;
					end
				end
				urx_pkg::S_PARITY: begin
					if (cur == spb) begin
						state_r <= urx_pkg::S_STOP;
						samp_r <= 5'h00;
					end else begin
						samp_r <= cur;
					end
				end
				urx_pkg::S_STOP: begin
					if (decide) begin
						state_r <= urx_pkg::S_IDLE;
						samp_r <= 5'h00;
					end else begin
						samp_r <= cur;
					end
				end
				default: state_r <= urx_pkg::S_IDLE;
			endcase
		end
	end

	// sample history; vote_r[0] also serves as the previous line level for edge search
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			vote_r <= 3'h7;
		end else if (!rx_en_r) begin
			vote_r <= 3'h7; // idle level, so no false edge after enable
		end else if (tick) begin
			vote_r <= {vote_r[1:0], rx_i};
		end
	end

	// shift register for data bits and the parity bit
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shift_r <= 9'h000;
			par_bit_r <= 1'b0;
		end else if (valid_start) begin
			shift_r <= 9'h000;
		end else if (decide && state_r == urx_pkg::S_DATA) begin
			shift_r[bit_idx_r] <= bit_val;
		end else if (decide && state_r == urx_pkg::S_PARITY) begin
			par_bit_r <= bit_val;
		end
	end

	// completed frame waits here while the buffer is full
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pend_valid_r <= 1'b0;
			pend_r <= '0;
		end else if (!rx_en_r) begin
			pend_valid_r <= 1'b0;
		end else if (frame_done) begin
			pend_valid_r <= 1'b1;
			pend_r.data <= shift_r;
			pend_r.frame_err <= ~bit_val;
			pend_r.par_err <= par_en_r & (^shift_r ^ par_odd_r ^ par_bit_r);
		end else if (push || overrun) begin
			pend_valid_r <= 1'b0;
		end
	end

	// overrun flag: set on loss, cleared by the next successful transfer, set wins
	always_ff @(posedge clk) begin
		if (!rst_n || !rx_en_r) begin
			ovr_r <= 1'b0;
		end else if (overrun) begin
			ovr_r <= 1'b1;
		end else if (push) begin
			ovr_r <= 1'b0;
		end
	end

	// two-entry receive buffer, flushed when the receiver is disabled
	always_ff @(posedge clk) begin
		if (!rst_n || !rx_en_r) begin
			count_r <= 2'h0;
			rd_ptr_r <= 1'b0;
		end else begin
			count_r <= count_r + {1'b0, push} - {1'b0, pop};
			if (pop) rd_ptr_r <= ~rd_ptr_r;
		end
	end

	// buffer storage written at the tail
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mem_r[0] <= '0;
			mem_r[1] <= '0;
		end else if (push) begin
			mem_r[rd_ptr_r ^ count_r[0]] <= pend_r;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_PUSH_SETS_RXC: assert property (push && count_r == 2'h0 |=> rx_done)
		else $error("receive-complete not set after push");
	AST_DISABLE_FLUSH: assert property (!rx_en_r |=> !rx_done && state_r == urx_pkg::S_IDLE)
		else $error("buffer or receiver not cleared on disable");
	AST_IRQ_ON_RISE: assert property ($rose(rx_done) && irq_en_r && global_irq_en |-> rx_irq)
		else $error("receive interrupt missing");
	AST_IRQ_ONLY_RXC: assert property (rx_irq |-> rx_done && irq_en_r)
		else $error("interrupt without receive-complete");
	AST_STATUS_WRITE_RO: assert property (wr_ack && wb_adr_i == urx_pkg::ADR_STATUS && !push && !overrun
		|=> ovr_r == $past(ovr_r))
		else $error("status write altered overrun");
	AST_FE_STOP: assert property (frame_done |=> pend_r.frame_err == !$past(bit_val))
		else $error("frame error does not match stop bit");
	AST_OVR_SET: assert property (overrun |=> ovr_r && !pend_valid_r)
		else $error("overrun not flagged");
	AST_OVR_CLR: assert property (push && !overrun && rx_en_r |=> !ovr_r)
		else $error("overrun not cleared on transfer");
	AST_UPE_OFF: assert property (!par_en_r |-> !par_err_vis)
		else $error("parity error visible while disabled");
	AST_NOISE_REJECT: assert property (decide && state_r == urx_pkg::S_START && bit_val && rx_en_r
		|=> state_r == urx_pkg::S_IDLE)
		else $error("noisy start bit not rejected");
	// a waiting frame may refill the freed slot one cycle later, so look right after the pop
	AST_POP_ADVANCE: assert property (pop && count_r == 2'h2 && !push && rx_en_r
		|=> rx_done && count_r == 2'h1)
		else $error("buffer did not advance on data read");
	AST_ACK_ONE: assert property ($rose(ack_r) |=> !ack_r)
		else $error("ack held longer than one cycle");

	COV_FRAME: cover property (frame_done ##[1:4] push);
	COV_OVERRUN: cover property (overrun);
	COV_NOISE: cover property (decide && state_r == urx_pkg::S_START && bit_val);
	COV_POP: cover property (pop && count_r == 2'h2);
endmodule

// ---- logic/urx_pkg.sv ----
// constants, field layouts and types of the serial receiver
// Behaviour
// - receive-complete high exactly while buffer holds data
// - receiver disable empties the receive buffer
// - interrupt requested while flag and enables set
// - error flags except overrun travel with each buffered character
// - status writes leave error flags unchanged
// - error flags never raise an interrupt
// - frame error mirrors first stop bit sampled
// - only the first stop bit is checked
// - overrun: buffer full, char waiting, new start
// - overrun clears when a frame enters buffer
// - parity error reads zero while checking disabled
// - checker on by enable bit, odd select
// - parity result buffered, valid until data read
// - disable stops reception at once, frees pin
// - sixteen samples per bit, eight at double speed
// - falling edge starts detection as sample one
// - vote start samples, high majority rejects noise
// - each valid start bit realigns bit timing
// - every bit decided by centre sample majority
// - first stop bit moves character into buffer
package urx_pkg;
	localparam int ADR_W = 5;
	localparam logic [4:0] ADR_STATUS = 5'h00;
	localparam logic [4:0] ADR_CONTROL = 5'h04;
	localparam logic [4:0] ADR_FORMAT = 5'h08;
	localparam logic [4:0] ADR_DATA = 5'h0C;
	localparam logic [4:0] ADR_BAUD = 5'h10;
	// status register bits
	localparam int ST_RX_DONE = 7;
	localparam int ST_FRAME_ERR = 4;
	localparam int ST_OVERRUN = 3;
	localparam int ST_PAR_ERR = 2;
	localparam int ST_DOUBLE = 1;
	// control register bits
	localparam int CT_IRQ_EN = 7;
	localparam int CT_RX_ENABLE = 4;
	localparam int CT_NINTH = 1;
	// frame format register bits
	localparam int FM_PAR_EN = 5;
	localparam int FM_PAR_ODD = 4;
	localparam int FM_STOP = 3;
	localparam int FM_CSZ_LSB = 0;
	localparam logic [2:0] CSZ_NINE = 3'h7;
	localparam logic [2:0] CSZ_RST = 3'h3;
	localparam logic [3:0] CHAR_BASE = 4'h5;
	localparam logic [3:0] CHAR_NINE = 4'h9;
	localparam logic [15:0] BAUD_RST = 16'h000C;
	// oversampling
	localparam logic [4:0] SPB_NORMAL = 5'h10;
	localparam logic [4:0] SPB_DOUBLE = 5'h08;
	localparam logic [4:0] VOTE_NORMAL = 5'h08;
	localparam logic [4:0] VOTE_DOUBLE = 5'h04;
	localparam logic [4:0] VOTE_SPAN = 5'h02;
	localparam logic [4:0] SAMPLE_ONE = 5'h01;
	localparam logic [1:0] FIFO_DEPTH = 2'h2;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_START = 3'b001,
		S_DATA = 3'b010,
		S_PARITY = 3'b011,
		S_STOP = 3'b100
	} urx_state_e;

	// one buffered character with its own error flags
	typedef struct packed {
		logic [8:0] data;
		logic frame_err;
		logic par_err;
	} urx_entry_s;
endpackage

// ---- test/urx_tx_model.sv ----
// behavioural remote transmitter that drives the receive line
`timescale 1ns/1ps
module urx_tx_model (
	output logic rx_o
	,input wire logic clk
);
	// the line has a pull-up, so it idles high between frames
	initial rx_o = 1'b1;
	// one frame: start, data lsb first, optional parity, one stop, then an idle bit time
	task automatic send(input logic [8:0] d, input int nb, input logic pen, input logic pb, input logic sb,
		input int spb);
		logic b;
		for (int i = 0; i < nb + 2 + int'(pen); i++) begin
			b = (i == 0) ? 1'b0 : (i <= nb) ? d[i-1] : (pen && i == nb + 1) ? pb : sb;
			@(posedge clk);
			rx_o <= b;
			repeat (spb - 1) @(posedge clk);
		end
		@(posedge clk);
		rx_o <= 1'b1;
		repeat (spb) @(posedge clk);
	endtask
	// short low pulse on an idle line, n samples long
	task automatic glitch(input int n);
		@(posedge clk);
		rx_o <= 1'b0;
		repeat (n) @(posedge clk);
		rx_o <= 1'b1;
	endtask
endmodule

// ---- test/urx_receiver_tb.sv ----
// self-checking bench for the serial receiver through its register bus
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module urx_receiver_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic gie = 1'b0;
	logic [3:0] sel = 4'hF;
	logic [4:0] adr = 5'h00;
	logic [31:0] dati = 32'h0;
	logic [31:0] dato;
	logic [31:0] q;
	logic ack;
	logic rx;
	logic irq;
	logic own;
	int fail_count = 0;
	int n_compared = 0;
	int cycles = 0;
	// 25 MHz system clock
	always #20 clk = ~clk;
	urx_receiver i_urx_receiver (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dati), .wb_dat_o(dato), .wb_ack_o(ack), .rx_i(rx),
		.global_irq_en(gie), .rx_irq(irq), .rx_pin_owned(own));
	urx_tx_model i_urx_tx_model (.clk(clk), .rx_o(rx));
	// verdict and end of run
	task wrap_up;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			wrap_up;
		end
	end
	// one classic cycle; write lands and read data is taken at the ack edge
	task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dati <= d;
		do @(posedge clk); while (ack !== 1'b1);
		q = dato;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// read a register and compare it
	task automatic rdc(input logic [4:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		`CHK(q, e)
	endtask
	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		`CHK(own, 1'b0)
		rdc(urx_pkg::ADR_STATUS, 32'h0);
		rdc(urx_pkg::ADR_CONTROL, 32'h0);
		rdc(urx_pkg::ADR_FORMAT, 32'h3);
		rdc(urx_pkg::ADR_BAUD, 32'hC);
		rdc(5'h14, 32'h0);
		xfer(1'b1, 5'h14, 32'hFF);
		xfer(1'b1, urx_pkg::ADR_BAUD, 32'h0);
		xfer(1'b1, urx_pkg::ADR_FORMAT, 32'h0B);
		xfer(1'b1, urx_pkg::ADR_CONTROL, 32'h90);
		gie <= 1'b1;
		// plain frame with two stop bits selected, interrupt on
		i_urx_tx_model.send(9'h0A5, 8, 1'b0, 1'b0, 1'b1, 16);
		`CHK(irq, 1'b1)
		`CHK(own, 1'b1)
		rdc(urx_pkg::ADR_STATUS, 32'h80);
		gie <= 1'b0;
		@(posedge clk);
		`CHK(irq, 1'b0)
		gie <= 1'b1;
		rdc(urx_pkg::ADR_DATA, 32'hA5);
		rdc(urx_pkg::ADR_STATUS, 32'h0);
		`CHK(irq, 1'b0)
		// stop bit low, interrupt enable off
		xfer(1'b1, urx_pkg::ADR_CONTROL, 32'h10);
		i_urx_tx_model.send(9'h03C, 8, 1'b0, 1'b0, 1'b0, 16);
		xfer(1'b1, urx_pkg::ADR_STATUS, 32'h0);
		rdc(urx_pkg::ADR_STATUS, 32'h90);
		`CHK(irq, 1'b0)
		rdc(urx_pkg::ADR_DATA, 32'h3C);
		rdc(urx_pkg::ADR_STATUS, 32'h0);
		// even and odd parity, good and bad parity bit
		for (int m = 0; m < 4; m++) begin
			xfer(1'b1, urx_pkg::ADR_FORMAT, {26'h0, 1'b1, m[0], 4'h3});
			i_urx_tx_model.send(9'h037, 8, 1'b1, 1'b1 ^ m[0] ^ m[1], 1'b1, 16);
			rdc(urx_pkg::ADR_STATUS, {24'h0, 1'b1, 4'h0, m[1], 2'h0});
			rdc(urx_pkg::ADR_DATA, 32'h37);
		end
		// nine-bit and five-bit characters
		xfer(1'b1, urx_pkg::ADR_FORMAT, 32'h07);
		i_urx_tx_model.send(9'h1C3, 9, 1'b0, 1'b0, 1'b1, 16);
		rdc(urx_pkg::ADR_CONTROL, 32'h12);
		rdc(urx_pkg::ADR_DATA, 32'hC3);
		xfer(1'b1, urx_pkg::ADR_FORMAT, 32'h00);
		i_urx_tx_model.send(9'h0F5, 5, 1'b0, 1'b0, 1'b1, 16);
		rdc(urx_pkg::ADR_DATA, 32'h15);
		xfer(1'b1, urx_pkg::ADR_FORMAT, 32'h03);
		// double speed, eight samples per bit
		xfer(1'b1, urx_pkg::ADR_STATUS, 32'h02);
		i_urx_tx_model.send(9'h05A, 8, 1'b0, 1'b0, 1'b1, 8);
		rdc(urx_pkg::ADR_STATUS, 32'h82);
		rdc(urx_pkg::ADR_DATA, 32'h5A);
		xfer(1'b1, urx_pkg::ADR_STATUS, 32'h0);
		// eight low samples: samples 9 and 10 high, so rejected
		i_urx_tx_model.glitch(8);
		repeat (200) @(posedge clk);
		rdc(urx_pkg::ADR_STATUS, 32'h0);
		// four frames without reading: third waits, fourth start overruns
		for (int k = 0; k < 4; k++) begin
			i_urx_tx_model.send(9'(k + 8'h41), 8, 1'b0, 1'b0, 1'b1, 16);
		end
		rdc(urx_pkg::ADR_STATUS, 32'h88);
		rdc(urx_pkg::ADR_DATA, 32'h41);
		rdc(urx_pkg::ADR_STATUS, 32'h80);
		rdc(urx_pkg::ADR_DATA, 32'h42);
		rdc(urx_pkg::ADR_DATA, 32'h44);
		rdc(urx_pkg::ADR_STATUS, 32'h0);
		// disable flushes the buffer and frees the pin
		i_urx_tx_model.send(9'h066, 8, 1'b0, 1'b0, 1'b1, 16);
		rdc(urx_pkg::ADR_STATUS, 32'h80);
		xfer(1'b1, urx_pkg::ADR_CONTROL, 32'h0);
		rdc(urx_pkg::ADR_STATUS, 32'h0);
		`CHK(own, 1'b0)
		i_urx_tx_model.send(9'h077, 8, 1'b0, 1'b0, 1'b1, 16);
		rdc(urx_pkg::ADR_STATUS, 32'h0);
		rdc(urx_pkg::ADR_DATA, 32'h0);
		wrap_up;
	end
endmodule
